// ### rtl/palr_pkg.sv
package palr_pkg;
    localparam int DATA_W        = 16;
    localparam int DP_W          = 9;
    localparam int DMA_W         = 7;
    localparam int AR_N          = 8;
    localparam int AR_SEL_W      = 3;
    // opcode fields
    localparam logic [6:0]  OP_DP_MEM_HI   = 7'h06;  // 0000 110, bit 8 must be 1
    localparam logic [7:0]  OP_DP_MEM      = 8'h0D;
    localparam logic [6:0]  OP_DP_IMM      = 7'h5E;  // 1011 110
    localparam logic [4:0]  OP_AR_MEM      = 5'h00;  // 00000 arx
    localparam logic [4:0]  OP_AR_SIMM     = 5'h16;  // 10110 arx
    localparam logic [12:0] OP_AR_LIMM     = 13'h17F0; // 1011 1111 1000 0 arx
    localparam int          IND_BIT        = 7;
    // register offsets, byte addresses
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_INSTR      = 8'h04;
    localparam logic [7:0]  REG_OPERAND    = 8'h08;
    localparam logic [7:0]  REG_STATUS_LD  = 8'h0C;
    localparam logic [7:0]  REG_DP         = 8'h10;
    localparam logic [7:0]  REG_ADDR       = 8'h14;
    localparam logic [7:0]  REG_CYCLES     = 8'h18;
    localparam logic [7:0]  REG_AUX_CMP    = 8'h1C;
    localparam logic [7:0]  REG_INDEX      = 8'h20;
    localparam logic [7:0]  REG_AR0        = 8'h40;
    // ctrl fields
    localparam int          CTRL_COMPAT    = 0;
    localparam int          CTRL_SAME_BLK  = 1;
    localparam int          CTRL_ARP_LSB   = 4;
    localparam int          CTRL_RPT_LSB   = 8;
    localparam int          RPT_W          = 8;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
    localparam logic [3:0]  BASE_CYCLES    = 4'h2;
    localparam logic [3:0]  SINGLE_ACCESS_RAM_PENALTY  = 4'h1;
    typedef enum logic [3:0] {
        PALR_IDLE = 4'b0001,
        PALR_EXEC = 4'b0010,
        PALR_WAIT = 4'b0100,
        PALR_DONE = 4'b1000
    } palr_state_t;
endpackage

// ### rtl/palr_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
interface palr_dec_if;
    import palr_pkg::*;
    logic [DATA_W-1:0]   instr;
    logic                is_dp_mem;
    logic                is_dp_imm;
    logic                is_ar_mem;
    logic                is_ar_simm;
    logic                is_ar_limm;
    logic                indirect;
    logic [AR_SEL_W-1:0] ar_sel;
    modport dec (input instr, output is_dp_mem, is_dp_imm, is_ar_mem, is_ar_simm, is_ar_limm, indirect, ar_sel);
    modport core (output instr, input is_dp_mem, is_dp_imm, is_ar_mem, is_ar_simm, is_ar_limm, indirect, ar_sel);
endinterface
`default_nettype wire

// ### rtl/palr_decode.sv
`timescale 1ns/1ns
`default_nettype none
module palr_decode
    import palr_pkg::*;
(
    palr_dec_if.dec d
);
    always_comb begin
        d.is_dp_mem  = d.instr[15:9] == OP_DP_MEM_HI && d.instr[8];
        d.is_dp_imm  = d.instr[15:9] == OP_DP_IMM;
        d.is_ar_mem  = d.instr[15:11] == OP_AR_MEM;
        d.is_ar_simm = d.instr[15:11] == OP_AR_SIMM;
        d.is_ar_limm = d.instr[15:3] == OP_AR_LIMM;
        d.indirect   = d.instr[IND_BIT];
        d.ar_sel     = d.is_ar_limm ? d.instr[2:0] : d.instr[10:8];
    end
endmodule // palr_decode
`default_nettype wire

// ### rtl/palr_core.sv
`timescale 1ns/1ns
`default_nettype none
module palr_core
    import palr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // core status
    output logic      [15:0] pc_o,
    output logic             busy_o
);
    palr_dec_if dif ();
    palr_decode u_dec (.d(dif));

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    palr_state_t       st_q, st_d;
    logic [31:0]       ctrl_q, ctrl_d;
    logic [15:0]       instr_q, instr_d;
    logic [15:0]       oper_q, oper_d;
    logic [15:0]       ext_q, ext_d;
    logic [DP_W-1:0]   dp_q, dp_d;
    logic [15:0]       addr_q, addr_d;
    logic [15:0]       pc_q, pc_d;
    logic [15:0]       cyc_cnt_q, cyc_cnt_d;
    logic [3:0]        wait_q, wait_d;
    logic [RPT_W-1:0]  rpt_q, rpt_d;
    logic [15:0]       cmp_q, cmp_d;
    logic [15:0]       idx_q, idx_d;
    logic [15:0]       ar_q [AR_N], ar_d [AR_N];
    logic [31:0]       rdat_d;
    logic              ack_q, ack_d;
    logic              req;
    logic [AR_SEL_W-1:0] aux_pointer_select;
    logic [15:0]       ld_val;
    logic              imm_form;
    logic              any_op;
    logic [3:0]        step_cyc;
    logic              first_exec;

    assign dif.instr = instr_q;
    assign req       = cyc_i && stb_i && !ack_q;
    assign aux_pointer_select       = ctrl_q[CTRL_ARP_LSB +: AR_SEL_W];
    assign imm_form  = dif.is_dp_imm || dif.is_ar_simm || dif.is_ar_limm;
    assign any_op    = dif.is_dp_mem || imm_form || dif.is_ar_mem;
    // count is cleared at launch and grows by at least two per pass
    assign first_exec = cyc_cnt_q == 16'h0000;

    always_comb begin
        // operand value: memory word, short or long constant
        ld_val = oper_q;
        if (dif.is_ar_simm) begin
            ld_val = {8'h00, instr_q[7:0]};
        end else if (dif.is_ar_limm) begin
            ld_val = ext_q;
        end
        step_cyc = BASE_CYCLES;
        // penalty paid once per run, not once per repetition
        if (!imm_form && ctrl_q[CTRL_SAME_BLK] && first_exec) begin
            step_cyc = BASE_CYCLES + SINGLE_ACCESS_RAM_PENALTY;
        end
    end

    always_comb begin
        st_d      = st_q;
        ctrl_d    = ctrl_q;
        instr_d   = instr_q;
        oper_d    = oper_q;
        ext_d     = ext_q;
        dp_d      = dp_q;
        addr_d    = addr_q;
        pc_d      = pc_q;
        cyc_cnt_d = cyc_cnt_q;
        wait_d    = wait_q;
        rpt_d     = rpt_q;
        cmp_d     = cmp_q;
        idx_d     = idx_q;
        ar_d      = ar_q;
        ack_d     = req;
        rdat_d    = 32'h0000_0000;
        unique case (st_q)
            PALR_IDLE: begin
                if (req && we_i) begin
                    if (adr_i == REG_CTRL) begin
                        ctrl_d = merge(ctrl_q, dat_i, sel_i);
                    end else if (adr_i == REG_INSTR) begin
                        instr_d = dat_i[15:0];
                        ext_d   = dat_i[31:16];
                    end else if (adr_i == REG_OPERAND) begin
                        // writing the operand launches execution
                        oper_d    = dat_i[15:0];
                        cyc_cnt_d = 16'h0000;
                        rpt_d     = ctrl_q[CTRL_RPT_LSB +: RPT_W];
                        st_d      = PALR_EXEC;
                    end else if (adr_i == REG_STATUS_LD) begin
                        dp_d = dat_i[DP_W-1:0];
                    end else if (adr_i >= REG_AR0 && adr_i < REG_AR0 + 8'h20) begin
                        ar_d[adr_i[4:2]] = dat_i[15:0];
                    end
                end
            end
            PALR_EXEC: begin
                if (dif.is_dp_mem) begin
                    dp_d = oper_q[DP_W-1:0];
                end else if (dif.is_dp_imm) begin
                    dp_d = instr_q[DP_W-1:0];
                end
                if (dif.is_ar_mem || dif.is_ar_simm || dif.is_ar_limm) begin
                    ar_d[dif.ar_sel] = ld_val;
                    if (!ctrl_q[CTRL_COMPAT]) begin
                        cmp_d = ld_val;
                        idx_d = ld_val;
                    end
                end
                if (!dif.indirect && !imm_form) begin
                    addr_d = {dp_q, instr_q[DMA_W-1:0]};
                end else if (dif.indirect && !imm_form) begin
                    addr_d = ar_q[aux_pointer_select];
                    // post-decrement unless this register is being loaded
                    if (!(dif.is_ar_mem && dif.ar_sel == aux_pointer_select)) begin
                        ar_d[aux_pointer_select] = ar_q[aux_pointer_select] - 16'h0001;
                    end
                end
                // a repeated instruction advances the pc only once
                if (first_exec) begin
                    pc_d = pc_q + (dif.is_ar_limm ? 16'h0002 : 16'h0001);
                end
                cyc_cnt_d = cyc_cnt_q + {12'h000, step_cyc};
                wait_d    = step_cyc - 4'h1;
                st_d      = any_op ? PALR_WAIT : PALR_DONE;
            end
            PALR_WAIT: begin
                if (wait_q > 4'h1) begin
                    wait_d = wait_q - 4'h1;
                end else if (rpt_q != '0 && !imm_form) begin
                    rpt_d = rpt_q - RPT_W'(1);
                    st_d  = PALR_EXEC;
                end else begin
                    st_d = PALR_DONE;
                end
            end
            PALR_DONE: begin
                st_d = PALR_IDLE;
            end
            default: st_d = PALR_IDLE;
        endcase
        if (req && !we_i) begin
            unique case (adr_i)
                REG_CTRL:     rdat_d = ctrl_q;
                REG_INSTR:    rdat_d = {ext_q, instr_q};
                REG_OPERAND:  rdat_d = {16'h0000, oper_q};
                REG_DP:       rdat_d = {23'h000000, dp_q};
                REG_ADDR:     rdat_d = {16'h0000, addr_q};
                REG_CYCLES:   rdat_d = {16'h0000, cyc_cnt_q};
                REG_AUX_CMP:  rdat_d = {16'h0000, cmp_q};
                REG_INDEX:    rdat_d = {16'h0000, idx_q};
                default: begin
                    if (adr_i >= REG_AR0 && adr_i < REG_AR0 + 8'h20) begin
                        rdat_d = {16'h0000, ar_q[adr_i[4:2]]};
                    end
                end
            endcase
            if (adr_i == REG_STATUS_LD) begin
                rdat_d = {15'h0000, (st_q != PALR_IDLE), pc_q};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q      <= PALR_IDLE;
            ctrl_q    <= CTRL_RESET;
            instr_q   <= 16'h0000;
            oper_q    <= 16'h0000;
            ext_q     <= 16'h0000;
            dp_q      <= '0;
            addr_q    <= 16'h0000;
            pc_q      <= 16'h0000;
            cyc_cnt_q <= 16'h0000;
            wait_q    <= 4'h0;
            rpt_q     <= '0;
            cmp_q     <= 16'h0000;
            idx_q     <= 16'h0000;
            for (int i = 0; i < AR_N; i++) begin
                ar_q[i] <= 16'h0000;
            end
            ack_q     <= 1'b0;
            dat_o     <= 32'h0000_0000;
        end else begin
            st_q      <= st_d;
            ctrl_q    <= ctrl_d;
            instr_q   <= instr_d;
            oper_q    <= oper_d;
            ext_q     <= ext_d;
            dp_q      <= dp_d;
            addr_q    <= addr_d;
            pc_q      <= pc_d;
            cyc_cnt_q <= cyc_cnt_d;
            wait_q    <= wait_d;
            rpt_q     <= rpt_d;
            cmp_q     <= cmp_d;
            idx_q     <= idx_d;
            ar_q      <= ar_d;
            ack_q     <= ack_d;
            dat_o     <= rdat_d;
        end
    end

    assign ack_o  = ack_q;
    assign pc_o   = pc_q;
    assign busy_o = st_q != PALR_IDLE;
endmodule // palr_core
`default_nettype wire

// ### tb/palr_core_props.sv
`timescale 1ns/1ns
`default_nettype none
module palr_core_props
    import palr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [15:0] pc_o,
    input wire logic        busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] pc_start_q;
    logic [15:0] pc_start_d;
    // pc held from the last idle cycle
    always_comb pc_start_d = busy_o ? pc_start_q : pc_o;
    always_ff @(posedge clk_i) pc_start_q <= pc_start_d;
    chk_ack_next:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    chk_ack_pulse:
        assert property (ack_o |=> !ack_o) else $error("ack too long");
    chk_ack_cause:
        assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    chk_reset_clear:
        assert property (disable iff (1'b0) rst_i |=> !ack_o && !busy_o && pc_o == 16'h0000)
        else $error("reset state wrong");
    chk_exec_start:
        assert property (cyc_i && stb_i && we_i && !ack_o && !busy_o && adr_i == REG_OPERAND |=> busy_o)
        else $error("no execution start");
    chk_busy_ends:
        assert property ($rose(busy_o) |-> ##[2:1000] !busy_o) else $error("busy hangs");
    chk_pc_idle:
        assert property (!busy_o ##1 !busy_o |-> $stable(pc_o)) else $error("pc moved while idle");
    chk_pc_step:
        assert property ($fell(busy_o) |-> ##[0:1] (pc_o == pc_start_q + 16'h0001 || pc_o == pc_start_q + 16'h0002))
        else $error("pc step wrong");
    chk_unmapped_zero:
        assert property (ack_o && !we_i && adr_i == 8'h24 |-> dat_o == 32'h0000_0000) else $error("unmapped read");
    cover property ($rose(busy_o));
    cover property (ack_o && !we_i);
    cover property ($fell(busy_o) && pc_o == pc_start_q + 16'h0002);
endmodule // palr_core_props
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import palr_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, busy_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, cyc_e;
    logic [15:0] pc_o, pc_e;
    logic [31:0] exp_q[$];
    int          compares, miscompares;
    integer      seed = 32'hC2DC;
    palr_core i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pc_o, .busy_o);
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        // hold the request until ack is seen high at a rising edge
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic run(input logic [31:0] ins, input logic [15:0] op, input int words, input int cyc);
        bus(1'b1, REG_INSTR, ins);
        bus(1'b1, REG_OPERAND, {16'hFFFF, op});
        do @(posedge clk_i); while (busy_o !== 1'b0);
        @(posedge clk_i);
        pc_e += 16'(words);
        // cycle register restarts at every launch
        cyc_e = 32'(cyc);
    endtask
    // read data checked in request order
    always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end
    initial begin
        logic [15:0] op;
        logic [8:0]  dp;
        {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {4'h8, 8'h00, 32'h0, 4'hF};
        {pc_e, cyc_e} = 48'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(REG_CTRL, CTRL_RESET);
        rd(REG_AR0, 32'h0);
        rd(8'h24, 32'h0);
        for (int i = 0; i < 3; i++) begin
            dp = (i == 0) ? 9'h1FF : 9'($random(seed));
            run({16'h0000, OP_DP_IMM, dp}, 16'h0000, 1, 2);
            rd(REG_DP, {23'h0, dp});
        end
        op = 16'($random(seed)) | 16'hFE00;
        run({16'h0000, OP_DP_MEM, 8'h05}, op, 1, 2);
        rd(REG_DP, {23'h0, op[8:0]});
        op = 16'($random(seed));
        dp = op[8:0];
        bus(1'b1, REG_STATUS_LD, {16'hFFFF, op});
        rd(REG_DP, {23'h0, dp});
        op = 16'($random(seed));
        run({16'h0000, OP_AR_MEM, 3'd2, 8'h11}, op, 1, 2);
        rd(REG_AR0 + 8'h08, {16'h0, op});
        rd(REG_ADDR, {16'h0, dp, 7'h11});
        rd(REG_AUX_CMP, 32'h0);
        op = 16'($random(seed)) | 16'h0080;
        run({16'h0000, OP_AR_SIMM, 3'd5, op[7:0]}, 16'hFFFF, 1, 2);
        rd(REG_AR0 + 8'h14, {24'h0, op[7:0]});
        run({op, OP_AR_LIMM, 3'd6}, 16'h0000, 2, 2);
        rd(REG_AR0 + 8'h18, {16'h0, op});
        rd(REG_STATUS_LD, {16'h0, pc_e});
        bus(1'b1, REG_CTRL, 32'h0000_0000);
        run({16'h0000, OP_AR_MEM, 3'd1, 8'h02}, op, 1, 2);
        rd(REG_AUX_CMP, {16'h0, op});
        rd(REG_INDEX, {16'h0, op});
        bus(1'b1, REG_CTRL, 32'h0000_0041);
        run({16'h0000, OP_AR_MEM, 3'd4, 8'h80}, op, 1, 2);
        rd(REG_AR0 + 8'h10, {16'h0, op});
        run({16'h0000, OP_AR_MEM, 3'd3, 8'h80}, 16'h1234, 1, 2);
        rd(REG_AR0 + 8'h10, {16'h0, op - 16'h0001});
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        run({16'h0000, OP_AR_MEM, 3'd0, 8'h01}, op, 1, 3);
        rd(REG_CYCLES, cyc_e);
        bus(1'b1, REG_CTRL, 32'h0000_0301);
        run({16'h0000, OP_AR_SIMM, 3'd0, 8'h5A}, op, 1, 2);
        rd(REG_CYCLES, cyc_e);
        run({16'h0000, OP_DP_IMM, 9'h033}, op, 1, 2);
        rd(REG_CYCLES, cyc_e);
        bus(1'b1, REG_CTRL, 32'h0000_0303);
        run({16'h0000, OP_AR_MEM, 3'd0, 8'h01}, op, 1, 9);
        rd(REG_CYCLES, cyc_e);
        repeat (3) @(posedge clk_i);
        complete_run();
    end
endmodule // tb_top
bind palr_core palr_core_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .pc_o, .busy_o);
`default_nettype wire
